// ### adc_wave_pkg.sv
// shared constants and types for the converter control block
package adc_wave_pkg;

  // ------------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_WAVE_MODE   = 8'h0D;
  localparam logic [7:0] ADDR_IRQ_EN3     = 8'hDB;
  localparam logic [7:0] ADDR_IRQ_ST3     = 8'hDE;
  localparam logic [7:0] ADDR_GAIN        = 8'hE8;
  localparam logic [7:0] ADDR_WAVE_FIRST  = 8'hE2;
  localparam logic [7:0] ADDR_WAVE_LAST   = 8'hE7;
  localparam logic [7:0] ADDR_CH1_HI      = 8'hE4;
  localparam logic [7:0] ADDR_CH2_HI      = 8'hE7;

  // ------------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------------
  localparam int          BIT_WAVE_READY  = 5;
  localparam int          BIT_IPEAK       = 4;
  localparam int          BIT_VPEAK       = 3;
  localparam int          BIT_CYC_END     = 2;
  localparam int          BIT_ZX_TIMEOUT  = 1;
  localparam int          BIT_ZX          = 0;
  localparam logic [7:0]  IRQ_EN3_MASK    = 8'h3F;
  localparam logic [7:0]  RST_WAVE_MODE   = 8'h00;
  localparam logic [7:0]  RST_IRQ_EN3     = 8'h00;
  localparam logic [7:0]  RST_GAIN        = 8'h00;

  // ------------------------------------------------------------------
  // converter figures
  // ------------------------------------------------------------------
  localparam int          MOD_DIV         = 5;
  localparam int          WAVE_DIV        = 160;
  localparam logic [23:0] FULL_SCALE_CODE = 24'h20_C49B;
  localparam logic [23:0] SAT_POS_CODE    = 24'h40_0000;
  localparam logic [23:0] SAT_NEG_CODE    = 24'hC0_0000;
  localparam logic [23:0] VOLT_POS_BOUND  = 24'h00_28F5;
  localparam logic [23:0] VOLT_NEG_BOUND  = 24'hFF_D70B;

  typedef enum logic [1:0] {
    RATE_FULL   = 2'b00,
    RATE_HALF   = 2'b01,
    RATE_QUART  = 2'b10,
    RATE_EIGHTH = 2'b11
  } wave_rate_e;

  typedef struct packed {
    logic [7:0]  wave_mode_config;
    logic [7:0]  metering_irq_enable_3;
    logic [7:0]  amp_gain_select;
    logic        wave_sample_ready;
    logic [2:0]  mod_cnt;
    logic [7:0]  wave_cnt;
    logic [2:0]  dec_cnt;
    logic [23:0] ch1_word;
    logic [23:0] ch2_word;
    logic [23:0] ch1_wave;
    logic [23:0] ch2_wave;
    logic [7:0]  rdata;
  } state_s;

endpackage : adc_wave_pkg

// ### adc_wave_ctrl.sv
// converter control, waveform sampling and third interrupt enable register
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE_01 - wave ready and enable five raise interrupt
// RULE_02 - current peak and enable four interrupt
// RULE_03 - voltage peak and enable three interrupt
// RULE_04 - cycle end and enable two interrupt
// RULE_05 - zero timeout and enable one interrupt
// RULE_06 - zero cross and enable zero interrupt
// RULE_07 - amplifier gains 1, 2, 4, 8, 16
// RULE_08 - gain low bits current, high voltage
// RULE_09 - samples feed metering and six registers
// RULE_10 - battery or sleep powers converters down
// RULE_11 - modulator at clock/5, 24-bit words
// RULE_12 - full scale gives nominal code, both channels; the voltage word is clipped to VOLT_POS_BOUND instead
// RULE_13 - output saturates at maximum magnitude
// RULE_14 - current samples at most clock/160
// RULE_15 - voltage samples at most clock/160
// RULE_16 - voltage codes within 16-bit bounds
// RULE_17 - rate field chooses four output rates
// RULE_18 - energy path never stalls for waveforms
// RULE_19 - high byte read latches samples
// RULE_20 - interrupt holds until ready bit cleared
// RULE_21 - ready flag set on new data
// RULE_22 - zero timeout flag from half cycles
// RULE_23 - rate codes decimate full stream
// RULE_24 - reserved enable bits read zero
module adc_wave_ctrl
  import adc_wave_pkg::*;
#(
  parameter int WORD_W = 24             // converter word width
) (
  input  wire logic              clk,              // 4.096 MHz class master clock
  input  wire logic              resetn,           // async reset, active low
  input  wire logic [7:0]        sfr_addr,         // register address
  input  wire logic              sfr_wr,           // write strobe
  input  wire logic              sfr_rd,           // read strobe
  input  wire logic [7:0]        sfr_wdata,        // write data
  output logic [7:0]             sfr_rdata,        // read data, registered
  input  wire logic              battery_power_mode, // low power mode one
  input  wire logic              sleep_power_mode, // low power mode two
  input  wire logic              ready_clear,      // status bit 5 cleared by core
  input  wire logic              current_peak_flag, // status flag level
  input  wire logic              voltage_peak_flag, // status flag level
  input  wire logic              line_cycle_end_flag, // status flag level
  input  wire logic              zero_cross_timeout_flag, // status flag level
  input  wire logic              zero_cross_flag,  // status flag level
  input  wire logic [WORD_W-1:0] filt_ch1,         // current filter output
  input  wire logic [WORD_W-1:0] filt_ch2,         // voltage filter output
  output logic                   mod_clk_en,       // modulator tick, clock/5
  output logic                   adc_powered,      // converters powered
  output logic [2:0]             current_gain,     // current amplifier code
  output logic [2:0]             voltage_gain,     // voltage amplifier code
  output logic [WORD_W-1:0]      dsp_ch1,          // current word to metering
  output logic [WORD_W-1:0]      dsp_ch2,          // voltage word to metering
  output logic                   sample_strobe,    // full-rate sample tick
  output logic                   wave_sample_ready, // status bit 5
  output logic                   meter_irq         // pending metering interrupt
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [WORD_W-1:0] sat(input logic [WORD_W-1:0] v);
    if (!v[WORD_W-1] && v > SAT_POS_CODE) begin
      return SAT_POS_CODE; // RULE_13
    end else if (v[WORD_W-1] && v < SAT_NEG_CODE) begin
      return SAT_NEG_CODE; // RULE_13
    end
    return v;
  endfunction : sat

  function automatic logic [WORD_W-1:0] vclip(input logic [WORD_W-1:0] v);
    if (!v[WORD_W-1] && v > VOLT_POS_BOUND) begin
      return VOLT_POS_BOUND; // RULE_16
    end else if (v[WORD_W-1] && v < VOLT_NEG_BOUND) begin
      return VOLT_NEG_BOUND; // RULE_16
    end
    return v;
  endfunction : vclip

  // gain codes above 3'b100 are not defined; clamp to x16
  function automatic logic [2:0] gsel(input logic [2:0] c);
    return (c > 3'h4) ? 3'h4 : c; // RULE_07
  endfunction : gsel

  function automatic logic [2:0] dec_limit(input logic [1:0] r);
    unique case (wave_rate_e'(r))
      RATE_FULL:   return 3'h0;
      RATE_HALF:   return 3'h1;
      RATE_QUART:  return 3'h3;
      RATE_EIGHTH: return 3'h7;
    endcase
  endfunction : dec_limit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_s      s_q;
  state_s      s_d;
  logic        powered;
  logic        mod_tick;
  logic        samp_tick;
  logic        wave_tick;
  logic        hi_read;
  logic [5:0]  flags;
  logic [23:0] wsel;

  assign powered   = !(battery_power_mode || sleep_power_mode); // RULE_10
  assign mod_tick  = powered && (s_q.mod_cnt == 3'(MOD_DIV - 1)); // RULE_11
  assign samp_tick = powered && (s_q.wave_cnt == 8'(WAVE_DIV - 1)); // RULE_14 RULE_15
  assign wave_tick = samp_tick && (s_q.dec_cnt == dec_limit(s_q.wave_mode_config[1:0])); // RULE_23
  assign hi_read   = sfr_rd && (sfr_addr == ADDR_CH1_HI || sfr_addr == ADDR_CH2_HI);

  always_comb begin
    wsel = 24'h00_0000;
    unique case (sfr_addr)
      8'hE2: wsel = {16'h0000, s_q.ch1_wave[7:0]};
      8'hE3: wsel = {16'h0000, s_q.ch1_wave[15:8]};
      8'hE4: wsel = {16'h0000, s_q.ch1_word[23:16]};
      8'hE5: wsel = {16'h0000, s_q.ch2_wave[7:0]};
      8'hE6: wsel = {16'h0000, s_q.ch2_wave[15:8]};
      8'hE7: wsel = {16'h0000, s_q.ch2_word[23:16]};
      default: wsel = 24'h00_0000;
    endcase
  end

  always_comb begin
    s_d = s_q;
    // ----------------------------------------------------------------
    // converter timing, stopped while powered down
    // ----------------------------------------------------------------
    if (powered) begin
      s_d.mod_cnt  = mod_tick ? 3'h0 : s_q.mod_cnt + 3'h1;
      s_d.wave_cnt = samp_tick ? 8'h00 : s_q.wave_cnt + 8'h01;
    end
    if (samp_tick) begin
      // metering path takes every sample regardless of waveform reads
      s_d.ch1_word = sat(filt_ch1); // RULE_09 RULE_12 RULE_18
      s_d.ch2_word = vclip(sat(filt_ch2)); // RULE_09 RULE_16 RULE_18
      s_d.dec_cnt  = wave_tick ? 3'h0 : s_q.dec_cnt + 3'h1; // RULE_17
    end
    // high byte read latches the whole word, low bytes then read coherent
    if (hi_read) begin
      s_d.ch1_wave = s_q.ch1_word; // RULE_19
      s_d.ch2_wave = s_q.ch2_word; // RULE_19
    end
    // set wins over clear
    if (wave_tick) begin
      s_d.wave_sample_ready = 1'b1; // RULE_21
    end else if (ready_clear) begin
      s_d.wave_sample_ready = 1'b0; // RULE_20
    end
    // ----------------------------------------------------------------
    // register writes and reads
    // ----------------------------------------------------------------
    if (sfr_wr) begin
      unique case (sfr_addr)
        ADDR_WAVE_MODE: s_d.wave_mode_config = sfr_wdata;
        ADDR_IRQ_EN3:   s_d.metering_irq_enable_3 = sfr_wdata & IRQ_EN3_MASK; // RULE_24
        ADDR_GAIN:      s_d.amp_gain_select = sfr_wdata; // RULE_07
        default:        s_d.wave_mode_config = s_q.wave_mode_config;
      endcase
    end
    s_d.rdata = 8'h00;
    if (sfr_rd) begin
      if (sfr_addr == ADDR_WAVE_MODE) begin
        s_d.rdata = s_q.wave_mode_config;
      end else if (sfr_addr == ADDR_IRQ_EN3) begin
        s_d.rdata = s_q.metering_irq_enable_3 & IRQ_EN3_MASK; // RULE_24
      end else if (sfr_addr == ADDR_GAIN) begin
        s_d.rdata = s_q.amp_gain_select;
      end else if (sfr_addr == ADDR_IRQ_ST3) begin
        s_d.rdata = {2'b00, s_q.wave_sample_ready, flags[4:0]};
      end else if (sfr_addr >= ADDR_WAVE_FIRST && sfr_addr <= ADDR_WAVE_LAST) begin
        s_d.rdata = wsel[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{wave_mode_config: RST_WAVE_MODE, metering_irq_enable_3: RST_IRQ_EN3,
               amp_gain_select: RST_GAIN, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // interrupt combine
  // ----------------------------------------------------------------
  assign flags = {s_q.wave_sample_ready, current_peak_flag, voltage_peak_flag,
                  line_cycle_end_flag, zero_cross_timeout_flag, zero_cross_flag};
  // zero timeout flag itself is made by the zero-cross logic outside
  assign meter_irq = |(flags & s_q.metering_irq_enable_3[5:0]); // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05 RULE_06 RULE_22

  assign sfr_rdata         = s_q.rdata;
  assign mod_clk_en        = mod_tick;
  assign adc_powered       = powered;
  assign current_gain      = gsel(s_q.amp_gain_select[2:0]); // RULE_08
  assign voltage_gain      = gsel(s_q.amp_gain_select[7:5]); // RULE_08
  assign dsp_ch1           = s_q.ch1_word;
  assign dsp_ch2           = s_q.ch2_word;
  assign sample_strobe     = samp_tick;
  assign wave_sample_ready = s_q.wave_sample_ready;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_IRQ_READY: assert property (s_q.wave_sample_ready && s_q.metering_irq_enable_3[5] |-> meter_irq) else $error("ready irq missing"); // RULE_01
  AST_IRQ_IPEAK: assert property (current_peak_flag && s_q.metering_irq_enable_3[4] |-> meter_irq) else $error("ipeak irq missing"); // RULE_02
  AST_IRQ_VPEAK: assert property (voltage_peak_flag && s_q.metering_irq_enable_3[3] |-> meter_irq) else $error("vpeak irq missing"); // RULE_03
  AST_IRQ_CYC: assert property (line_cycle_end_flag && s_q.metering_irq_enable_3[2] |-> meter_irq) else $error("cycle irq missing"); // RULE_04
  AST_IRQ_ZERO_CROSS_TIMEOUT_FLAG: assert property (zero_cross_timeout_flag && s_q.metering_irq_enable_3[1] |-> meter_irq) else $error("zero_cross_timeout_flag irq missing"); // RULE_05
  AST_IRQ_ZX: assert property (zero_cross_flag && s_q.metering_irq_enable_3[0] |-> meter_irq) else $error("zx irq missing"); // RULE_06
  AST_NO_SAMPLE_LOWPWR: assert property (!powered |-> !samp_tick && !mod_tick) else $error("sample while down"); // RULE_10
  sequence s_mod_gap;
    !mod_tick [*4];
  endsequence
  AST_MOD_DIV: assert property (mod_tick ##1 powered [*5] |-> mod_tick) else $error("mod div"); // RULE_11
  AST_MOD_SPACE: assert property (mod_tick |=> s_mod_gap) else $error("modulator tick too soon"); // RULE_11
  AST_SAT: assert property (samp_tick |=> !(!dsp_ch1[23] && dsp_ch1 > SAT_POS_CODE)) else $error("no saturation"); // RULE_13
  AST_VBOUND: assert property (samp_tick |=> !(!dsp_ch2[23] && dsp_ch2 > VOLT_POS_BOUND)) else $error("voltage bound"); // RULE_16
  AST_READY_HOLD: assert property (wave_sample_ready && !ready_clear |=> wave_sample_ready) else $error("ready dropped"); // RULE_20
  AST_READY_SET: assert property (wave_tick |=> wave_sample_ready) else $error("ready not set"); // RULE_21
  AST_LATCH: assert property (hi_read |=> s_q.ch1_wave == $past(s_q.ch1_word)) else $error("no latch"); // RULE_19
  AST_EN_RSVD: assert property (s_q.metering_irq_enable_3[7:6] == 2'b00) else $error("reserved bits set"); // RULE_24

  // ----------------------------------------------------------------
  // register port checks
  // ----------------------------------------------------------------
  // read data stands for one cycle only, so an idle cycle must show zero
  AST_RDATA_IDLE: assert property ( // RULE_09
    !sfr_rd |=> sfr_rdata == 8'h00
  ) else $error("read data not idle");
  AST_RD_MODE: assert property ( // RULE_17
    sfr_rd && sfr_addr == ADDR_WAVE_MODE |=> sfr_rdata == $past(s_q.wave_mode_config)
  ) else $error("mode readback wrong");
  AST_RD_EN3: assert property ( // RULE_24
    sfr_rd && sfr_addr == ADDR_IRQ_EN3 |=> sfr_rdata[7:6] == 2'b00
  ) else $error("reserved enable bits read");
  AST_RD_GAIN: assert property ( // RULE_08
    sfr_rd && sfr_addr == ADDR_GAIN |=> sfr_rdata == $past(s_q.amp_gain_select)
  ) else $error("gain readback wrong");
  AST_RD_STATUS: assert property ( // RULE_21
    sfr_rd && sfr_addr == ADDR_IRQ_ST3 |=> sfr_rdata[5] == $past(s_q.wave_sample_ready)
  ) else $error("status ready bit wrong");
  AST_WR_MODE: assert property ( // RULE_17
    sfr_wr && sfr_addr == ADDR_WAVE_MODE |=> s_q.wave_mode_config == $past(sfr_wdata)
  ) else $error("mode write lost");
  AST_WR_GAIN: assert property ( // RULE_07
    sfr_wr && sfr_addr == ADDR_GAIN |=> s_q.amp_gain_select == $past(sfr_wdata)
  ) else $error("gain write lost");
  AST_WR_EN3: assert property ( // RULE_24
    sfr_wr && sfr_addr == ADDR_IRQ_EN3 |=>
      s_q.metering_irq_enable_3 == ($past(sfr_wdata) & IRQ_EN3_MASK)
  ) else $error("enable write wrong");

  // ----------------------------------------------------------------
  // gain decode checks
  // ----------------------------------------------------------------
  AST_GAIN_RANGE: assert property ( // RULE_07
    current_gain <= 3'h4 && voltage_gain <= 3'h4
  ) else $error("gain code out of range");
  AST_GAIN_MAP_I: assert property ( // RULE_08
    s_q.amp_gain_select[2:0] <= 3'h4 |-> current_gain == s_q.amp_gain_select[2:0]
  ) else $error("current gain field wrong");
  AST_GAIN_MAP_V: assert property ( // RULE_08
    s_q.amp_gain_select[7:5] <= 3'h4 |-> voltage_gain == s_q.amp_gain_select[7:5]
  ) else $error("voltage gain field wrong");

  // ----------------------------------------------------------------
  // converter word, timing and power checks
  // ----------------------------------------------------------------
  AST_SAT_NEG: assert property ( // RULE_13
    samp_tick |=> !(dsp_ch1[23] && dsp_ch1 < SAT_NEG_CODE)
  ) else $error("no negative saturation");
  AST_VBOUND_NEG: assert property ( // RULE_16
    samp_tick |=> !(dsp_ch2[23] && dsp_ch2 < VOLT_NEG_BOUND)
  ) else $error("voltage negative bound");
  AST_SAMP_RESTART: assert property ( // RULE_14
    samp_tick |=> s_q.wave_cnt == 8'h00
  ) else $error("sample counter not restarted");
  AST_WAVE_SUB: assert property ( // RULE_23
    wave_tick |-> samp_tick
  ) else $error("waveform tick off the sample grid");
  // metering words only move on a sample tick, whatever the core reads
  AST_DSP_HOLD: assert property ( // RULE_18
    !samp_tick |=> $stable(dsp_ch1) && $stable(dsp_ch2)
  ) else $error("metering word moved");
  AST_POWER_STOP: assert property ( // RULE_10
    !powered |=> $stable(s_q.wave_cnt) && $stable(s_q.mod_cnt)
  ) else $error("timing ran while down");
  AST_MOD_POWERED: assert property ( // RULE_10
    mod_tick |-> powered
  ) else $error("modulator tick while down");

  // ----------------------------------------------------------------
  // ready flag and latch checks
  // ----------------------------------------------------------------
  AST_READY_CLEAR: assert property ( // RULE_20
    ready_clear && !wave_tick && wave_sample_ready |=> !wave_sample_ready
  ) else $error("ready not cleared");
  AST_READY_NO_SET: assert property ( // RULE_21
    !wave_tick && !wave_sample_ready |=> !wave_sample_ready
  ) else $error("ready set without data");
  AST_LATCH_V: assert property ( // RULE_19
    hi_read |=> s_q.ch2_wave == $past(s_q.ch2_word)
  ) else $error("no voltage latch");
  // low bytes must not tear between the high byte read and their own read
  AST_WAVE_HOLD: assert property ( // RULE_19
    !hi_read |=> $stable(s_q.ch1_wave) && $stable(s_q.ch2_wave)
  ) else $error("latched word moved");
  sequence s_hi1_read;
    hi_read && sfr_addr == ADDR_CH1_HI;
  endsequence
  sequence s_mid1_read;
    sfr_rd && sfr_addr == 8'hE3;
  endsequence
  AST_HI_THEN_MID: assert property ( // RULE_19
    s_hi1_read ##2 s_mid1_read |=> sfr_rdata == $past(s_q.ch1_wave[15:8])
  ) else $error("mid byte not from latch");

endmodule : adc_wave_ctrl

`default_nettype wire

// ### filt_source.sv
// decimation filter stand-in feeding the converter words
`timescale 1ns/1ps
`default_nettype none
module filt_source (
  input  wire logic        clk,           // master clock
  input  wire logic        resetn,        // async reset, active low
  input  wire logic        sample_strobe, // full-rate tick from the block
  input  wire logic [23:0] ch1_set,       // word the current filter settles to
  input  wire logic [23:0] ch2_set,       // word the voltage filter settles to
  output logic      [23:0] filt_ch1,      // current filter output
  output logic      [23:0] filt_ch2       // voltage filter output
);
  // ----------------------------------------------------------------
  // output moves only on a tick, like a real decimator
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      filt_ch1 <= 24'h00_0000;
      filt_ch2 <= 24'h00_0000;
    end else if (sample_strobe) begin
      filt_ch1 <= ch1_set;
      filt_ch2 <= ch2_set;
    end
  end
endmodule : filt_source
`default_nettype wire

// ### adc_waveform_sampling_irq_test.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_waveform_sampling_irq_test;
  import adc_wave_pkg::*;
  logic clk = 0, resetn = 0, wr = 0, rd = 0, bat = 0, slp = 0, clr = 0;
  logic [7:0] addr = 0, wdata = 0, v, rdata;
  logic [4:0] fl = 0;
  logic [23:0] s1 = 0, s2 = 0, f1, f2, d1, d2;
  logic [2:0] cg, vg;
  logic mod_en, pwr, strobe, ready, irq;
  int n_fail = 0, n_tests = 0, n;
  realtime t0;
  always #12.5 clk = ~clk;
  filt_source u_src (.clk(clk), .resetn(resetn), .sample_strobe(strobe), .ch1_set(s1),
    .ch2_set(s2), .filt_ch1(f1), .filt_ch2(f2));
  adc_wave_ctrl u_dut (.clk(clk), .resetn(resetn), .sfr_addr(addr), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata), .battery_power_mode(bat),
    .sleep_power_mode(slp), .ready_clear(clr), .current_peak_flag(fl[4]),
    .voltage_peak_flag(fl[3]), .line_cycle_end_flag(fl[2]),
    .zero_cross_timeout_flag(fl[1]), .zero_cross_flag(fl[0]), .filt_ch1(f1),
    .filt_ch2(f2), .mod_clk_en(mod_en), .adc_powered(pwr), .current_gain(cg),
    .voltage_gain(vg), .dsp_ch1(d1), .dsp_ch2(d2), .sample_strobe(strobe),
    .wave_sample_ready(ready), .meter_irq(irq));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1;
    @(posedge clk); wr <= 0;
    @(posedge clk); #1;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk); addr <= a; rd <= 1;
    @(posedge clk); rd <= 0;
    #1 d = rdata;
  endtask : rd_reg
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd_reg(a, v);
    check({16'h0000, v}, {16'h0000, e});
  endtask : rd_chk
  // w: 0 sample tick, 1 modulator tick, 2 ready flag; bounded poll
  task wait_hit(input int w);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk); #1;
      if ((w == 0 && strobe === 1) || (w == 1 && mod_en === 1) || (w == 2 && ready === 1))
        return;
    end
    n_fail++;
    $display("BAD %0t event never seen", $time);
  endtask : wait_hit
  task gap(input int w, output int c);
    wait_hit(w);
    // ready may already stand: clear it and catch a fresh set edge
    if (w == 2) begin
      @(posedge clk); clr <= 1;
      @(posedge clk); clr <= 0;
      wait_hit(w);
    end
    t0 = $realtime;
    if (w == 2) begin
      @(posedge clk); clr <= 1;
      @(posedge clk); clr <= 0;
    end
    wait_hit(w);
    c = int'(($realtime - t0) / 25.0);
  endtask : gap
  // filter words only reach the block on a tick, so let three pass
  task feed(input logic [23:0] a, input logic [23:0] b);
    @(posedge clk); s1 <= a; s2 <= b;
    repeat (3) wait_hit(0);
    @(posedge clk); #1;
  endtask : feed
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial begin
    #(25.0 * 40000);
    n_fail++;
    close_out();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1;
    rd_chk(ADDR_IRQ_EN3, RST_IRQ_EN3);
    rd_chk(ADDR_WAVE_MODE, RST_WAVE_MODE);
    rd_chk(ADDR_GAIN, RST_GAIN);
    rd_chk(8'h55, 8'h00);
    wr_reg(ADDR_IRQ_EN3, 8'hFF);
    rd_chk(ADDR_IRQ_EN3, IRQ_EN3_MASK);
    for (int g = 0; g < 6; g++) begin
      wr_reg(ADDR_GAIN, {3'(g), 2'b00, 3'(5 - g)});
      check({21'h0, cg}, (5 - g > 4) ? 24'h4 : 24'(5 - g));
      check({21'h0, vg}, (g > 4) ? 24'h4 : 24'(g));
    end
    for (int k = 0; k < 5; k++) begin
      wr_reg(ADDR_IRQ_EN3, 8'h01 << k);
      @(posedge clk); fl <= ~(5'h01 << k);
      @(posedge clk); #1 check({23'h0, irq}, 24'h0);
      @(posedge clk); fl <= 5'h01 << k;
      @(posedge clk); #1 check({23'h0, irq}, 24'h1);
    end
    @(posedge clk); fl <= 0;
    wr_reg(ADDR_IRQ_EN3, 8'h20);
    wait_hit(2);
    repeat (200) @(posedge clk);
    #1 check({23'h0, irq}, 24'h1);
    @(posedge clk); clr <= 1;
    @(posedge clk); clr <= 0;
    #1 check({22'h0, ready, irq}, 24'h0);
    rd_chk(ADDR_IRQ_ST3, 8'h00);
    gap(0, n);
    check(24'(n), 24'(WAVE_DIV));
    gap(1, n);
    check(24'(n), 24'(MOD_DIV));
    for (int r = 0; r < 4; r++) begin
      wr_reg(ADDR_WAVE_MODE, {6'b0, 2'(r)});
      gap(2, n);
      gap(2, n);
      check(24'(n), 24'(WAVE_DIV << r));
    end
    feed(FULL_SCALE_CODE, 24'h00_1234);
    check(d1, FULL_SCALE_CODE);
    check(d2, 24'h00_1234);
    rd_chk(ADDR_CH1_HI, 8'h20);
    rd_chk(8'hE3, 8'hC4);
    feed(24'h12_3456, 24'h00_0567);
    rd_chk(8'hE3, 8'hC4);
    rd_chk(8'hE2, 8'h9B);
    rd_chk(ADDR_CH2_HI, 8'h00);
    rd_chk(8'hE5, 8'h67);
    feed(24'h7F_FFFF, 24'h7F_FFFF);
    check(d1, SAT_POS_CODE);
    check(d2, VOLT_POS_BOUND);
    feed(24'h80_0000, 24'h80_0000);
    check(d1, SAT_NEG_CODE);
    check(d2, VOLT_NEG_BOUND);
    for (int m = 1; m < 3; m++) begin
      @(posedge clk); {slp, bat} <= 2'(m);
      n = 0;
      repeat (400) begin
        @(posedge clk); #1;
        if (strobe !== 0 || mod_en !== 0) n++;
      end
      check({23'h0, pwr}, 24'h0);
      check(24'(n), 24'h0);
    end
    close_out();
  end
endmodule : adc_waveform_sampling_irq_test
`default_nettype wire
